// ==== core/accumulator_store_round_shift.sv ====
`timescale 1ns/1ps
`include "store_path_cfg.svh"


module accumulator_store_round_shift (
    input wire logic ref_clk,
    input wire logic rst,
    input store_path_pkg::request_t req,
    input wire logic [39:0] acc_a,
    input wire logic [39:0] acc_b,
    input wire logic [15:0] xbus_read_data,
    input wire logic round_mode_select,
    input wire logic data_write_saturation_enable,
    input wire logic pointer_load,
    input wire logic [15:0] pointer_load_value,
    output store_path_pkg::mem_write_t mem_write,
    output logic [15:0] writeback_pointer_reg,
    output store_path_pkg::shift_out_t shift_out
);
    import store_path_pkg::*;

    // ==========================================================
    // State
    path_state_t state_reg;
    path_state_t state_next;

    logic is_store;
    logic is_accum;
    logic wb_allowed;
    logic [39:0] round_src;
    logic round_en;
    logic [15:0] rnd_word;
    logic [23:0] rnd_value;
    logic rnd_overflow;
    logic [15:0] sat_word;
    logic [39:0] shift_operand;
    logic [39:0] shift_result;
    logic shift_left;
    logic [15:0] shift_word;

    // ==========================================================
    // Round source and mode
    always_comb begin
        is_store = (req.cmd == cmd_store_trunc) || (req.cmd == cmd_store_round);
        is_accum = (req.cmd == cmd_accum_class);
        case (req.accum_op)
            multiply_op: wb_allowed = 1'b0;
            negated_multiply_op: wb_allowed = 1'b0;
            squared_difference_op: wb_allowed = 1'b0;
            squared_difference_accum_op: wb_allowed = 1'b0;
            default: wb_allowed = 1'b1;
        endcase
        // Stores take the target, write-back the other one
        if (is_accum) begin
            round_src = req.target_b ? acc_a : acc_b;
        end else begin
            round_src = req.target_b ? acc_b : acc_a;
        end
        // Write-back is never truncated
        round_en = is_accum || (req.cmd == cmd_store_round);
    end

    round_unit u_round (
        .acc(round_src),
        .round_en(round_en),
        .convergent(round_mode_select),
        .word(rnd_word),
        .value(rnd_value),
        .overflow(rnd_overflow)
    );

    // ==========================================================
    // Data space write saturation
    always_comb begin
        sat_word = rnd_word;
        if (data_write_saturation_enable && rnd_overflow) begin
            // Sign comes from the source, not the rounded word
            if (round_src[`ACC_SIGN_BIT]) begin
                sat_word = `SAT_NEG_WORD;
            end else begin
                sat_word = `SAT_POS_WORD;
            end
        end
    end

    // ==========================================================
    // Barrel shifter operand
    always_comb begin
        shift_left = req.shift_amount[4];
        case (req.shift_src)
            src_acc_a: shift_operand = acc_a;
            src_acc_b: shift_operand = acc_b;
            src_xbus: begin
                if (shift_left) begin
                    shift_operand = {24'h000000, xbus_read_data};
                end else begin
                    shift_operand = {{8{req.shift_arith & xbus_read_data[15]}},
                                     xbus_read_data, 16'h0000};
                end
            end
            default: shift_operand = `WIDE_RESET;
        endcase
    end

    barrel_shifter u_shift (
        .operand(shift_operand),
        .amount(req.shift_amount),
        .arith(req.shift_arith),
        .result(shift_result)
    );

    always_comb begin
        if (shift_left) begin
            shift_word = shift_result[15:0];
        end else begin
            shift_word = shift_result[`ACC_HI_MSB:`XBUS_RIGHT_LSB];
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        state_next.wr.valid = 1'b0;
        state_next.sh.valid = 1'b0;
        if (pointer_load) begin
            state_next.pointer = pointer_load_value;
        end
        // Accumulators are only read here, never written
        case (req.cmd)
            cmd_store_trunc, cmd_store_round: begin
                state_next.wr.valid = 1'b1;
                state_next.wr.addr = req.store_addr;
                state_next.wr.data = sat_word;
            end
            cmd_accum_class: begin
                if (wb_allowed) begin
                    case (req.wb_mode)
                        wb_direct: begin
                            state_next.pointer = rnd_word;
                        end
                        wb_post_inc: begin
                            state_next.wr.valid = 1'b1;
                            state_next.wr.addr = state_reg.pointer;
                            state_next.wr.data = sat_word;
                            state_next.pointer = state_reg.pointer + `PTR_STEP;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            cmd_shift: begin
                state_next.sh.valid = 1'b1;
                state_next.sh.wide = shift_result;
                state_next.sh.word = shift_word;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg.wr.valid <= 1'b0;
            state_reg.wr.addr <= `PTR_RESET;
            state_reg.wr.data <= `WORD_RESET;
            state_reg.sh.valid <= 1'b0;
            state_reg.sh.wide <= `WIDE_RESET;
            state_reg.sh.word <= `WORD_RESET;
            state_reg.pointer <= `PTR_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign mem_write = state_reg.wr;
    assign writeback_pointer_reg = state_reg.pointer;
    assign shift_out = state_reg.sh;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic wb_post;
    logic wb_dir;
    logic wb_blocked;
    logic sat_quiet;
    logic [39:0] wb_other;
    logic [39:0] store_target;
    always_comb begin
        wb_post = is_accum && wb_allowed && (req.wb_mode == wb_post_inc);
        wb_dir = is_accum && wb_allowed && (req.wb_mode == wb_direct);
        wb_blocked = is_accum && !wb_allowed && !pointer_load;
        sat_quiet = !data_write_saturation_enable;
        wb_other = req.target_b ? acc_a : acc_b;
        store_target = req.target_b ? acc_b : acc_a;
    end

    a_wb_excluded_ops: assert property (
        wb_blocked |=> !mem_write.valid && $stable(writeback_pointer_reg)
    ) else $error("excluded op wrote back");

    a_wb_direct_load: assert property (
        wb_dir |=> writeback_pointer_reg == $past(rnd_word)
    ) else $error("direct write-back pointer wrong");

    a_wb_post_step: assert property (
        wb_post |=> writeback_pointer_reg == $past(writeback_pointer_reg) + 16'h0002
    ) else $error("pointer not stepped by two");

    a_wb_bus_addr: assert property (
        wb_post |=> mem_write.valid && mem_write.addr == $past(writeback_pointer_reg)
    ) else $error("write-back address wrong");

    a_trunc_pass: assert property (
        req.cmd == cmd_store_trunc && sat_quiet
        |=> mem_write.data == $past(round_src[31:16])
    ) else $error("truncated store altered");

    a_conv_round: assert property (
        req.cmd == cmd_store_round && sat_quiet && !round_mode_select
        |=> mem_write.data == 16'($past(round_src[31:16]) + {15'h0000, $past(round_src[15])})
    ) else $error("conventional round wrong");

    a_conv_tie: assert property (
        req.cmd == cmd_store_round && sat_quiet && round_mode_select
        && round_src[15:0] == 16'h8000
        |=> mem_write.data == 16'($past(round_src[31:16]) + {15'h0000, $past(round_src[16])})
    ) else $error("convergent tie wrong");

    a_sat_positive: assert property (
        is_store && data_write_saturation_enable && !round_src[39]
        && round_src[39:31] != 9'h000
        |=> mem_write.data == 16'h7FFF
    ) else $error("positive saturation missed");

    a_sat_negative: assert property (
        is_store && data_write_saturation_enable && round_src[39]
        && round_src[39:31] != 9'h1FF && !round_src[15]
        |=> mem_write.data == 16'h8000
    ) else $error("negative saturation missed");

    a_shift_zero: assert property (
        req.cmd == cmd_shift && req.shift_amount == 5'sh00 && req.shift_src != src_xbus
        |=> shift_out.valid && shift_out.wide == $past(shift_operand)
    ) else $error("zero shift changed operand");

    a_xbus_word_keep: assert property (
        req.cmd == cmd_shift && req.shift_src == src_xbus && req.shift_amount == 5'sh00
        |=> shift_out.word == $past(xbus_read_data)
    ) else $error("x bus word misplaced");

    a_store_pulse: assert property (
        is_store
        |=> mem_write.valid && mem_write.addr == $past(req.store_addr)
    ) else $error("store write missing");

    a_idle_quiet: assert property (
        req.cmd == cmd_idle
        |=> !mem_write.valid && !shift_out.valid
    ) else $error("output pulse without command");

    a_direct_no_write: assert property (
        wb_dir
        |=> !mem_write.valid
    ) else $error("direct write-back wrote memory");

    a_load_pointer: assert property (
        pointer_load && !wb_dir && !wb_post
        |=> writeback_pointer_reg == $past(pointer_load_value)
    ) else $error("pointer load lost");

    a_wb_rounded: assert property (
        wb_post && sat_quiet && !round_mode_select
        |=> mem_write.data == 16'($past(wb_other[31:16]) + {15'h0000, $past(wb_other[15])})
    ) else $error("write-back not rounded");

    a_wb_sat_pos: assert property (
        wb_post && data_write_saturation_enable && rnd_overflow && !wb_other[39]
        |=> mem_write.data == 16'h7FFF
    ) else $error("write-back saturation missed");

    a_conv_nontie: assert property (
        req.cmd == cmd_store_round && sat_quiet && round_mode_select
        && store_target[15:0] != 16'h8000
        |=> mem_write.data == 16'($past(store_target[31:16]) + {15'h0000, $past(store_target[15])})
    ) else $error("convergent non-tie wrong");

    a_sat_in_range: assert property (
        is_store && data_write_saturation_enable && !rnd_overflow
        |=> mem_write.data == $past(rnd_word)
    ) else $error("in-range store altered");

    a_sat_off_pass: assert property (
        is_store && sat_quiet
        |=> mem_write.data == $past(rnd_word)
    ) else $error("unsaturated store altered");

    a_sat_sign_src: assert property (
        is_store && data_write_saturation_enable && rnd_overflow
        |=> mem_write.data == ($past(store_target[39]) ? 16'h8000 : 16'h7FFF)
    ) else $error("saturation sign wrong");

    a_shift_cycle: assert property (
        req.cmd == cmd_shift
        |=> shift_out.valid && !mem_write.valid
    ) else $error("shift result late");

    a_left_sixteen: assert property (
        req.cmd == cmd_shift && req.shift_src == src_acc_a && req.shift_amount == 5'sh10
        |=> shift_out.wide == {$past(acc_a[23:0]), 16'h0000}
    ) else $error("left shift by sixteen wrong");

    a_right_arith: assert property (
        req.cmd == cmd_shift && req.shift_src == src_acc_b && req.shift_amount == 5'sh0F
        && req.shift_arith
        |=> shift_out.wide == {{15{$past(acc_b[39])}}, $past(acc_b[39:15])}
    ) else $error("arithmetic right shift wrong");

    a_xbus_left_place: assert property (
        req.cmd == cmd_shift && req.shift_src == src_xbus && req.shift_amount == 5'sh1C
        |=> shift_out.wide == {20'h00000, $past(xbus_read_data), 4'h0}
    ) else $error("x bus left placement wrong");

    a_xbus_right_word: assert property (
        req.cmd == cmd_shift && req.shift_src == src_xbus && req.shift_amount == 5'sh03
        && !req.shift_arith
        |=> shift_out.word == {3'b000, $past(xbus_read_data[15:3])}
    ) else $error("x bus right word wrong");

    c_post_inc: cover property (wb_post ##1 wb_post);
    c_sat_pos: cover property (is_store && data_write_saturation_enable && rnd_overflow);
    c_left_x: cover property (req.cmd == cmd_shift && req.shift_src == src_xbus && shift_left);
    c_tie: cover property (req.cmd == cmd_store_round && round_src[15:0] == 16'h8000);

endmodule

// ==== core/store_path_cfg.svh ====
`ifndef STORE_PATH_CFG_SVH
`define STORE_PATH_CFG_SVH

// ==========================================================
// Widths and field positions
`define ACC_W 40
`define WORD_W 16
`define ADDR_W 16
`define ACC_SIGN_BIT 39
`define ACC_HI_MSB 31
`define ACC_HI_LSB 16
`define ROUND_BIT 15
`define XBUS_RIGHT_LSB 16

// ==========================================================
// Saturation limits, round tie pattern and pointer step
`define SAT_POS_WORD 16'h7FFF
`define SAT_NEG_WORD 16'h8000
`define TIE_LOW_WORD 16'h8000
`define PTR_STEP 16'h0002

// ==========================================================
// Reset values
`define PTR_RESET 16'h0000
`define WORD_RESET 16'h0000
`define WIDE_RESET 40'h00_0000_0000

`endif

// ==== core/store_path_pkg.sv ====
package store_path_pkg;

    typedef enum logic [2:0] {
        cmd_idle = 3'b000,
        cmd_store_trunc = 3'b001,
        cmd_store_round = 3'b010,
        cmd_accum_class = 3'b011,
        cmd_shift = 3'b100
    } command_t;

    typedef enum logic [2:0] {
        op_mul_acc = 3'b000,
        op_mul_sub = 3'b001,
        op_clear = 3'b010,
        op_move_store = 3'b011,
        multiply_op = 3'b100,
        negated_multiply_op = 3'b101,
        squared_difference_op = 3'b110,
        squared_difference_accum_op = 3'b111
    } accum_op_t;

    typedef enum logic [1:0] {
        wb_none = 2'b00,
        wb_direct = 2'b01,
        wb_post_inc = 2'b10
    } wb_mode_t;

    typedef enum logic [1:0] {
        src_acc_a = 2'b00,
        src_acc_b = 2'b01,
        src_xbus = 2'b10
    } shift_src_t;

    typedef struct packed {
        command_t cmd;
        accum_op_t accum_op;
        logic target_b;
        wb_mode_t wb_mode;
        logic [15:0] store_addr;
        shift_src_t shift_src;
        logic signed [4:0] shift_amount;
        logic shift_arith;
    } request_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] data;
    } mem_write_t;

    typedef struct packed {
        logic valid;
        logic [39:0] wide;
        logic [15:0] word;
    } shift_out_t;

    typedef struct packed {
        mem_write_t wr;
        shift_out_t sh;
        logic [15:0] pointer;
    } path_state_t;

endpackage

// ==== core/round_unit.sv ====
`timescale 1ns/1ps
`include "store_path_cfg.svh"

module round_unit (
    input wire logic [39:0] acc,
    input wire logic round_en,
    input wire logic convergent,
    output logic [15:0] word,
    output logic [23:0] value,
    output logic overflow
);
    logic inc;
    logic tie;

    always_comb begin
        tie = (acc[15:0] == `TIE_LOW_WORD);
        inc = round_en & acc[`ROUND_BIT] & (~convergent | ~tie | acc[`ACC_HI_LSB]);
        value = acc[`ACC_SIGN_BIT:`ACC_HI_LSB] + {23'h000000, inc};
        word = value[15:0];
        // Outside the 1.15 range once guard and sign bits disagree
        overflow = ~((&value[23:15]) | ~(|value[23:15]));
    end

endmodule

// ==== core/barrel_shifter.sv ====
`timescale 1ns/1ps
`include "store_path_cfg.svh"

module barrel_shifter (
    input wire logic [39:0] operand,
    input wire logic signed [4:0] amount,
    input wire logic arith,
    output logic [39:0] result
);
    logic [4:0] mag;

    always_comb begin
        mag = amount[4] ? 5'(-amount) : amount;
        if (amount[4]) begin
            result = operand << mag;
        end else if (arith) begin
            result = 40'($signed(operand) >>> mag);
        end else begin
            result = operand >> mag;
        end
    end

endmodule

// ==== verif/xbus_mem_model.sv ====
`timescale 1ns/1ps

module xbus_mem_model (
    input wire logic ref_clk,
    input store_path_pkg::mem_write_t mem_write,
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data
);
    import store_path_pkg::*;

    logic [15:0] mem [logic [15:0]];

    function automatic logic [15:0] peek(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : 16'h0000;
    endfunction

    task automatic poke(input logic [15:0] a, input logic [15:0] d);
        mem[a] = d;
    endtask

    // ==========================================================
    // Write port over whole space, registered read port
    initial rd_data = 16'h0000;
    always @(posedge ref_clk) begin
        if (mem_write.valid === 1'b1) begin
            mem[mem_write.addr] = mem_write.data;
        end
        rd_data <= peek(rd_addr);
    end
endmodule

// ==== verif/accumulator_store_round_shift_tb_top.sv ====
`timescale 1ns/1ps

module accumulator_store_round_shift_tb_top;
    import store_path_pkg::*;

    typedef struct packed {
        logic [39:0] acc;
        logic rnd;
        logic conv;
        logic sat;
        logic tb;
        logic [15:0] exp;
    } store_row_t;

    logic ref_clk;
    logic rst;
    request_t req;
    logic [39:0] acc_a;
    logic [39:0] acc_b;
    logic [15:0] rd_addr;
    logic [15:0] xbus_word;
    logic round_mode_select;
    logic data_write_saturation_enable;
    logic pointer_load;
    logic [15:0] pointer_load_value;
    mem_write_t mem_write;
    logic [15:0] writeback_pointer_reg;
    shift_out_t shift_out;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    // ==========================================================
    // Store cases: acc, round, convergent, saturate, target B, word
    store_row_t rows [11] = '{
        '{40'h00_1234_8000, 1'b1, 1'b0, 1'b0, 1'b0, 16'h1235},
        '{40'h00_1234_8000, 1'b1, 1'b1, 1'b0, 1'b1, 16'h1234},
        '{40'h00_1235_8000, 1'b1, 1'b1, 1'b0, 1'b0, 16'h1236},
        '{40'h00_1234_7FFF, 1'b1, 1'b0, 1'b0, 1'b1, 16'h1234},
        '{40'h00_1234_FFFF, 1'b0, 1'b0, 1'b0, 1'b0, 16'h1234},
        '{40'h00_7FFF_8000, 1'b1, 1'b0, 1'b1, 1'b0, 16'h7FFF},
        '{40'h00_7FFF_8000, 1'b1, 1'b0, 1'b0, 1'b1, 16'h8000},
        '{40'hFF_7FFF_0000, 1'b0, 1'b0, 1'b1, 1'b0, 16'h8000},
        '{40'h01_0000_0000, 1'b0, 1'b0, 1'b1, 1'b1, 16'h7FFF},
        '{40'hFF_8000_0000, 1'b0, 1'b0, 1'b1, 1'b0, 16'h8000},
        '{40'h00_1234_8001, 1'b1, 1'b1, 1'b0, 1'b0, 16'h1235}
    };

    accumulator_store_round_shift dut_u (
        .ref_clk(ref_clk),
        .rst(rst),
        .req(req),
        .acc_a(acc_a),
        .acc_b(acc_b),
        .xbus_read_data(xbus_word),
        .round_mode_select(round_mode_select),
        .data_write_saturation_enable(data_write_saturation_enable),
        .pointer_load(pointer_load),
        .pointer_load_value(pointer_load_value),
        .mem_write(mem_write),
        .writeback_pointer_reg(writeback_pointer_reg),
        .shift_out(shift_out)
    );

    xbus_mem_model mem_u (
        .ref_clk(ref_clk),
        .mem_write(mem_write),
        .rd_addr(rd_addr),
        .rd_data(xbus_word)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic request_t mk(command_t c, accum_op_t op, logic tb, wb_mode_t wb,
                                    logic [15:0] a);
        request_t r;
        r = '0;
        r.cmd = c;
        r.accum_op = op;
        r.target_b = tb;
        r.wb_mode = wb;
        r.store_addr = a;
        return r;
    endfunction

    task automatic issue(input request_t r);
        req = r;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic do_shift(input shift_src_t s, input logic signed [4:0] amt, input logic ar,
                            input logic [39:0] av, input logic [15:0] x,
                            input logic [39:0] ew, input logic [15:0] eword);
        request_t r;
        req.cmd = cmd_idle;
        mem_u.poke(16'h0100, x);
        rd_addr = 16'h0100;
        acc_a = (s == src_acc_b) ? ~av : av;
        acc_b = (s == src_acc_b) ? av : ~av;
        @(posedge ref_clk);
        #1;
        r = mk(cmd_shift, op_mul_acc, 1'b0, wb_none, 16'h0000);
        r.shift_src = s;
        r.shift_amount = amt;
        r.shift_arith = ar;
        issue(r);
        check(40'(shift_out.valid), 40'h1);
        check(shift_out.wide, ew);
        if (s == src_xbus) begin
            check(40'(shift_out.word), 40'(eword));
        end
    endtask

    initial begin
        rst = 1'b1;
        req = '0;
        acc_a = '0;
        acc_b = '0;
        rd_addr = '0;
        round_mode_select = 1'b0;
        data_write_saturation_enable = 1'b0;
        pointer_load = 1'b0;
        pointer_load_value = '0;
        repeat (20) @(posedge ref_clk);
        #1;
        check(40'(writeback_pointer_reg), 40'h0);
        check(40'(mem_write.valid), 40'h0);
        rst = 1'b0;
        @(posedge ref_clk);
        #1;
        foreach (rows[i]) begin
            acc_a = rows[i].tb ? ~rows[i].acc : rows[i].acc;
            acc_b = rows[i].tb ? rows[i].acc : ~rows[i].acc;
            round_mode_select = rows[i].conv;
            data_write_saturation_enable = rows[i].sat;
            issue(mk(rows[i].rnd ? cmd_store_round : cmd_store_trunc, op_mul_acc, rows[i].tb,
                     wb_none, 16'(16'h0A00 + 2 * i)));
            check(40'(mem_write.valid), 40'h1);
            check(40'(mem_write.addr), 40'(16'h0A00 + 2 * i));
            check(40'(mem_write.data), 40'(rows[i].exp));
        end
        req.cmd = cmd_idle;
        @(posedge ref_clk);
        #1;
        check(40'(mem_write.valid), 40'h0);
        // Pointer load, then back-to-back post-increment write-back
        round_mode_select = 1'b0;
        data_write_saturation_enable = 1'b0;
        pointer_load = 1'b1;
        pointer_load_value = 16'h0800;
        @(posedge ref_clk);
        #1;
        pointer_load = 1'b0;
        check(40'(writeback_pointer_reg), 40'h0800);
        acc_a = 40'h00_0000_0000;
        acc_b = 40'h00_4000_8000;
        req = mk(cmd_accum_class, op_mul_acc, 1'b0, wb_post_inc, 16'h0000);
        @(posedge ref_clk);
        #1;
        check(40'(mem_write.addr), 40'h0800);
        check(40'(mem_write.data), 40'h4001);
        check(40'(writeback_pointer_reg), 40'h0802);
        acc_b = 40'h00_7FFF_FFFF;
        data_write_saturation_enable = 1'b1;
        @(posedge ref_clk);
        #1;
        req.cmd = cmd_idle;
        check(40'(mem_write.addr), 40'h0802);
        check(40'(mem_write.data), 40'h7FFF);
        check(40'(writeback_pointer_reg), 40'h0804);
        @(posedge ref_clk);
        #1;
        check(40'(mem_u.peek(16'h0800)), 40'h4001);
        // Direct write-back loads the pointer, no memory write
        acc_a = 40'h00_7FFF_8000;
        issue(mk(cmd_accum_class, op_mul_sub, 1'b1, wb_direct, 16'h0000));
        check(40'(writeback_pointer_reg), 40'h8000);
        check(40'(mem_write.valid), 40'h0);
        // Excluded operations never write back
        for (int k = 4; k < 8; k++) begin
            issue(mk(cmd_accum_class, accum_op_t'(3'(k)), 1'b0, wb_post_inc, 16'h0000));
            check(40'(mem_write.valid), 40'h0);
            check(40'(writeback_pointer_reg), 40'h8000);
        end
        acc_b = 40'h00_1234_0000;
        issue(mk(cmd_accum_class, op_move_store, 1'b0, wb_post_inc, 16'h0000));
        check(40'(mem_write.data), 40'h1234);
        check(40'(writeback_pointer_reg), 40'h8002);
        // Shifter cases
        do_shift(src_xbus, -5'sd4, 1'b0, 40'h0, 16'h0001, 40'h00_0000_0010, 16'h0010);
        do_shift(src_xbus, 5'sd3, 1'b1, 40'h0, 16'h8000, 40'hFF_F000_0000, 16'hF000);
        do_shift(src_xbus, 5'sd3, 1'b0, 40'h0, 16'h8000, 40'h00_1000_0000, 16'h1000);
        do_shift(src_xbus, 5'sd0, 1'b0, 40'h0, 16'hABCD, 40'h00_ABCD_0000, 16'hABCD);
        do_shift(src_acc_a, -5'sd16, 1'b0, 40'h00_0000_1234, 16'h0, 40'h00_1234_0000, 16'h0);
        do_shift(src_acc_b, 5'sd15, 1'b1, 40'h80_0000_0000, 16'h0, 40'hFF_FF00_0000, 16'h0);
        do_shift(src_acc_a, 5'sd0, 1'b0, 40'h5A_1234_5678, 16'h0, 40'h5A_1234_5678, 16'h0);
        // Reset in mid-run clears the pointer at once
        req.cmd = cmd_idle;
        rst = 1'b1;
        #1;
        check(40'(writeback_pointer_reg), 40'h0);
        @(posedge ref_clk);
        #1;
        rst = 1'b0;
        @(posedge ref_clk);
        #1;
        check(40'(shift_out.valid), 40'h0);
        check(shift_out.wide, 40'h0);
        check(40'(writeback_pointer_reg), 40'h0);
        report_and_stop();
    end
endmodule
